// [design/bcu_branch_unit.sv]
// branch control unit: decode, condition, target, latency and hold-off
// Functional notes
// - less-than-zero literal branch: pc plus literal
// - nonzero branches: pc plus source or literal
// - delay flag lets following instruction complete
// - no delay flag and taken: squash next
// - delayed less-than literal form differs by flag
// - delayed nonzero forms differ only by flag
// - register nonzero decoded by opcode and condition
// - literal branch cycles one, two, three
// - register branch cycles one, two, three
// - literal sign-extended from sixteen bits
// - preceding prefix supplies upper literal half
// - hold interrupts and breaks over delayed branch
// - link bit writes own pc to destination
// - absolute bit jumps to source, else relative
// - absolute forms set absolute bit
// - delayed forms set flag, link only delayed
// - unconditional branches two or three cycles
// - link without delay slot is undefined
`timescale 1ns/1ps
module bcu_branch_unit #(
  parameter int XW = bcu_pkg::XLEN
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic ISSUE_VALID_I,
  input wire logic [31:0] ISSUE_INSN_I,
  input wire logic [XW-1:0] ISSUE_PC_I,
  input wire logic [XW-1:0] COMPARE_SOURCE_I,
  input wire logic [XW-1:0] OFFSET_SOURCE_I,
  input wire logic SLOT_DONE_I,
  input wire logic IRQ_REQ_I,
  input wire logic HW_BREAK_REQ_I,
  output logic BUSY_O,
  output logic REDIRECT_O,
  output logic [XW-1:0] NEXT_PC_O,
  output logic SQUASH_O,
  output logic LINK_WE_O,
  output logic [4:0] LINK_DEST_O,
  output logic [XW-1:0] LINK_DATA_O,
  output logic IRQ_TAKE_O,
  output logic HW_BREAK_TAKE_O,
  output logic ILLEGAL_O,
  output logic [1:0] LATENCY_O
);
  import bcu_pkg::*;

  // how the unit sits in the pipeline:
  // - a word is taken on a rising edge with ISSUE_VALID_I high and BUSY_O low
  // - the answer (redirect, squash, link write, next pc, latency) shows one
  //   cycle after the issue edge and the pulses stand for that cycle only
  // - a taken branch without a delay slot keeps BUSY_O up for two cycles so
  //   that fetch refills from the target; the squash pulse kills the word
  //   already fetched behind the branch
  // - a taken branch with a delay slot keeps BUSY_O up for one cycle and then
  //   until the slot word reports completion on SLOT_DONE_I
  // - a prefix word only arms the upper literal half for the very next
  //   issued word; any other issued word drops it again
  // - events (interrupt, hardware break) are only accepted from idle and never
  //   in the issue cycle of a branch, so a delayed branch and its slot word
  //   always retire as a pair before an event can cut in
  // - the interrupt has priority when both requests are up in the same cycle
  // limitation: no prediction is modelled, so a literal branch that is not
  // taken always reports one cycle and a taken one two or three
  // limitation: the slot word is trusted to be a plain word; a prefix, branch
  // or break in the slot is the supplier's fault and is not detected here
  // trade-off: the target adder runs every cycle from the live inputs, which
  // costs some power but keeps the answer a single cycle after issue
  // the undefined link form without a delay slot is flagged as illegal and
  // changes nothing else, so software sees a clean trap point

  typedef struct packed {
    bcu_state_e st;
    logic [1:0] cnt;
    logic slot;
    logic pfx_vld;
    logic [15:0] pfx_val;
    logic busy;
    logic redirect;
    logic [XW-1:0] next_pc;
    logic squash;
    logic link_we;
    logic [4:0] link_dest;
    logic [XW-1:0] link_data;
    logic irq_take;
    logic brk_take;
    logic illegal;
    logic [1:0] lat;
  } bcu_state_s;

  bcu_state_s s_q, s_d;

  // literal operand: prefix upper half or sign extension
  function automatic logic [XW-1:0] lit_operand(input logic [15:0] lit,
                                               input logic pv,
                                               input logic [15:0] hi);
    logic [31:0] w;
    w = pv ? {hi, lit} : {{16{lit[15]}}, lit};
    return XW'(w);
  endfunction

  logic [5:0] opc;
  logic dflag;
  logic [3:0] cond;
  logic is_reg_cond, is_imm_cond, is_unc, is_pfx, is_branch;
  logic u_d, u_a, u_l;
  logic take;
  logic [XW-1:0] lit, target;

  // decode and resolve the issued word
  always_comb begin
    opc = ISSUE_INSN_I[OPC_LSB +: 6];
    dflag = ISSUE_INSN_I[DSLOT_BIT];
    cond = ISSUE_INSN_I[COND_LSB +: 4];
    u_d = ISSUE_INSN_I[UNC_D_BIT];
    u_a = ISSUE_INSN_I[UNC_A_BIT];
    u_l = ISSUE_INSN_I[UNC_L_BIT];
    is_reg_cond = (opc == OPC_REG_COND) && (cond == COND_NE || cond == COND_LT);
    is_imm_cond = (opc == OPC_IMM_COND) && (cond == COND_NE || cond == COND_LT);
    is_unc = (opc == OPC_REG_UNCOND);
    is_pfx = (opc == OPC_PREFIX);
    is_branch = is_reg_cond || is_imm_cond || is_unc;
    lit = lit_operand(ISSUE_INSN_I[LIT_LSB +: 16], s_q.pfx_vld, s_q.pfx_val);
    // signed compare against zero
    if (cond == COND_LT) begin
      take = $signed(COMPARE_SOURCE_I) < 0;
    end else begin
      take = COMPARE_SOURCE_I != '0;
    end
    if (is_unc) begin
      take = 1'b1;
      dflag = u_d;
    end
    if (is_unc && u_a) begin
      target = OFFSET_SOURCE_I;
    end else if (is_imm_cond) begin
      target = ISSUE_PC_I + lit;
    end else begin
      target = ISSUE_PC_I + OFFSET_SOURCE_I;
    end
  end

  // next state; outputs are registered copies in the struct
  always_comb begin
    s_d = s_q;
    s_d.redirect = 1'b0;
    s_d.squash = 1'b0;
    s_d.link_we = 1'b0;
    s_d.illegal = 1'b0;
    s_d.irq_take = 1'b0;
    s_d.brk_take = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (ISSUE_VALID_I) begin
          // prefix only lives for the very next word
          s_d.pfx_vld = is_pfx;
          s_d.pfx_val = ISSUE_INSN_I[LIT_LSB +: 16];
          if (is_unc && u_l && !u_d) begin
            s_d.illegal = 1'b1;
          end else if (is_branch) begin
            if (take) begin
              s_d.redirect = 1'b1;
              s_d.next_pc = target;
              s_d.squash = !dflag;
              s_d.lat = dflag ? LAT_TAKEN_DSLOT : LAT_TAKEN_FLUSH;
              s_d.slot = dflag;
              s_d.cnt = dflag ? 2'h1 : 2'h2;
              s_d.st = ST_BUSY;
              s_d.busy = 1'b1;
            end else begin
              s_d.next_pc = ISSUE_PC_I + PC_STEP;
              s_d.lat = LAT_NOT_TAKEN;
            end
            if (is_unc && u_l) begin
              s_d.link_we = 1'b1;
              s_d.link_dest = ISSUE_INSN_I[DST_LSB +: 5];
              s_d.link_data = ISSUE_PC_I;
            end
          end else begin
            s_d.irq_take = IRQ_REQ_I;
            s_d.brk_take = HW_BREAK_REQ_I && !IRQ_REQ_I;
          end
        end else begin
          s_d.irq_take = IRQ_REQ_I;
          s_d.brk_take = HW_BREAK_REQ_I && !IRQ_REQ_I;
        end
      end
      ST_BUSY: begin
        // extra cycles of the branch itself
        s_d.cnt = s_q.cnt - 2'h1;
        if (s_q.cnt == 2'h1) begin
          s_d.st = s_q.slot ? ST_SLOT : ST_IDLE;
          s_d.busy = s_q.slot;
        end
      end
      ST_SLOT: begin
        // slot instruction completes before events are accepted
        if (SLOT_DONE_I) begin
          s_d.st = ST_IDLE;
          s_d.busy = 1'b0;
          s_d.slot = 1'b0;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_q <= '{st: ST_IDLE, next_pc: PC_RESET, link_data: PC_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign BUSY_O = s_q.busy;
  assign REDIRECT_O = s_q.redirect;
  assign NEXT_PC_O = s_q.next_pc;
  assign SQUASH_O = s_q.squash;
  assign LINK_WE_O = s_q.link_we;
  assign LINK_DEST_O = s_q.link_dest;
  assign LINK_DATA_O = s_q.link_data;
  assign IRQ_TAKE_O = s_q.irq_take;
  assign HW_BREAK_TAKE_O = s_q.brk_take;
  assign ILLEGAL_O = s_q.illegal;
  assign LATENCY_O = s_q.lat;

  // no event is taken while a delayed branch or its slot runs
  chk_irq_held: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (s_q.st != ST_IDLE) |=> !IRQ_TAKE_O && !HW_BREAK_TAKE_O)
    else $error("event taken during branch");
  // taken without slot squashes and costs three
  chk_flush_lat: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (REDIRECT_O && SQUASH_O) |-> LATENCY_O == 2'h3 && BUSY_O ##1 BUSY_O ##1 !BUSY_O)
    else $error("flush latency wrong");
  // delayed branch waits in slot state
  sequence s_dslot_issue;
    REDIRECT_O && !SQUASH_O;
  endsequence
  chk_dslot_lat: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    s_dslot_issue |-> LATENCY_O == 2'h2 ##1 BUSY_O)
    else $error("delay slot latency wrong");
  // link data is the branch's own pc
  chk_link_pc: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    LINK_WE_O |-> LINK_DATA_O == $past(ISSUE_PC_I))
    else $error("link data wrong");
  // not taken steps by four
  chk_seq_step: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_branch && !take && !(is_unc && u_l && !u_d))
    |=> NEXT_PC_O == $past(ISSUE_PC_I) + 32'h0000_0004 && !REDIRECT_O)
    else $error("not-taken pc wrong");
  // absolute target is the source value
  chk_abs_tgt: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_unc && u_a && u_d)
    |=> REDIRECT_O && NEXT_PC_O == $past(OFFSET_SOURCE_I))
    else $error("absolute target wrong");
  // negative source takes less-than branch
  chk_lt_take: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_imm_cond && cond == COND_LT
     && COMPARE_SOURCE_I[XW-1]) |=> REDIRECT_O)
    else $error("lt branch not taken");
  // nonzero register branch target
  chk_ne_tgt: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_reg_cond && cond == COND_NE && COMPARE_SOURCE_I != '0)
    |=> REDIRECT_O && NEXT_PC_O == $past(ISSUE_PC_I) + $past(OFFSET_SOURCE_I))
    else $error("ne target wrong");
  // undefined link form flagged
  chk_no_link: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_unc && u_l && !u_d) |=> ILLEGAL_O && !LINK_WE_O)
    else $error("undefined link accepted");
  // literal extension
  chk_lit_ext: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_imm_cond && take && !s_q.pfx_vld)
    |=> NEXT_PC_O == $past(ISSUE_PC_I)
        + {{16{$past(ISSUE_INSN_I[15])}}, $past(ISSUE_INSN_I[15:0])})
    else $error("literal extension wrong");
  // prefix supplies the upper half of the literal
  chk_pfx_upper: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_imm_cond && take && s_q.pfx_vld)
    |=> NEXT_PC_O == $past(ISSUE_PC_I) + {$past(s_q.pfx_val), $past(ISSUE_INSN_I[15:0])})
    else $error("prefixed literal wrong");
  // a squash never comes without a redirect
  chk_squash_pair: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    SQUASH_O |-> REDIRECT_O)
    else $error("squash without redirect");
  // not taken costs one cycle and leaves the unit free
  chk_nt_lat: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_branch && !take && !(is_unc && u_l && !u_d))
    |=> LATENCY_O == 2'h1 && !BUSY_O && !SQUASH_O)
    else $error("not-taken latency wrong");
  // link only on delayed forms, into the named register
  chk_link_dest: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    LINK_WE_O |-> BUSY_O && !SQUASH_O && LINK_DEST_O == $past(ISSUE_INSN_I[25:21]))
    else $error("link destination wrong");
  // slot state holds until the slot word completes
  chk_slot_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (s_q.st == ST_SLOT && !SLOT_DONE_I) |=> BUSY_O)
    else $error("slot released early");
  // relative unconditional target
  chk_rel_tgt: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    (ISSUE_VALID_I && !BUSY_O && is_unc && !u_a && u_d)
    |=> REDIRECT_O && NEXT_PC_O == $past(ISSUE_PC_I) + $past(OFFSET_SOURCE_I))
    else $error("relative target wrong");
endmodule

// [design/bcu_pkg.sv]
// package for the branch control unit: opcodes, fields, latencies
package bcu_pkg;
  localparam int XLEN = 32;
  // major opcodes
  localparam logic [5:0] OPC_REG_COND = 6'h27;
  localparam logic [5:0] OPC_IMM_COND = 6'h2F;
  localparam logic [5:0] OPC_REG_UNCOND = 6'h26;
  localparam logic [5:0] OPC_PREFIX = 6'h2C;
  // field positions (bit 31 is the leftmost instruction bit)
  localparam int OPC_LSB = 26;
  localparam int DST_LSB = 21;
  localparam int SRC_A_LSB = 16;
  localparam int SRC_B_LSB = 11;
  localparam int LIT_LSB = 0;
  localparam int DSLOT_BIT = 25;
  localparam int COND_LSB = 21;
  localparam int UNC_D_BIT = 20;
  localparam int UNC_A_BIT = 19;
  localparam int UNC_L_BIT = 18;
  // condition codes, low four bits of the condition field
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_LT = 4'h2;
  localparam logic [XLEN-1:0] PC_STEP = 32'h0000_0004;
  localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;
  // cycle counts
  localparam logic [1:0] LAT_NOT_TAKEN = 2'h1;
  localparam logic [1:0] LAT_TAKEN_DSLOT = 2'h2;
  localparam logic [1:0] LAT_TAKEN_FLUSH = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BUSY = 4'h2,
    ST_SLOT = 4'h4,
    ST_HOLD = 4'h8
  } bcu_state_e;
endpackage

// [tb/bcu_slot_model.sv]
// slot model: the delay-slot word finishes after a set wait
`timescale 1ns/1ps
module bcu_slot_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic redir_i,
  input wire logic squash_i,
  input wire logic [2:0] dly_i,
  output logic done_o
);
  int cnt = -1;
  initial done_o = 1'b0;
  // slot only ever holds a plain word, so completion is a bare pulse
  always @(posedge clk_i) begin
    #1;
    if (!rstn_i) cnt = -1;
    // one extra cycle: the unit only looks for completion once in slot state
    else if (redir_i && !squash_i) cnt = dly_i + 1;
    done_o = (cnt == 0);
    if (cnt >= 0) cnt--;
  end
endmodule

// [tb/branch_control_unit_tb_top.sv]
// bench: random and corner branches through the branch unit
`timescale 1ns/1ps
module branch_control_unit_tb_top;
  import bcu_pkg::*;
  logic clk, rstn, vld, done, irq, brk, busy, rd, sq, lwe, it, bt, ill;
  logic [31:0] w, pc, a, b, npc, ldat, r;
  logic [4:0] ldst;
  logic [1:0] lat;
  logic [2:0] dly;
  int n_errors = 0, checks = 0, cyc = 0;
  integer seed = 32'hC117;
  bcu_branch_unit i_bcu_branch_unit (.CORE_CLK_I(clk), .RSTN_I(rstn),
    .ISSUE_VALID_I(vld), .ISSUE_INSN_I(w), .ISSUE_PC_I(pc),
    .COMPARE_SOURCE_I(a), .OFFSET_SOURCE_I(b), .SLOT_DONE_I(done),
    .IRQ_REQ_I(irq), .HW_BREAK_REQ_I(brk), .BUSY_O(busy), .REDIRECT_O(rd),
    .NEXT_PC_O(npc), .SQUASH_O(sq), .LINK_WE_O(lwe), .LINK_DEST_O(ldst),
    .LINK_DATA_O(ldat), .IRQ_TAKE_O(it), .HW_BREAK_TAKE_O(bt),
    .ILLEGAL_O(ill), .LATENCY_O(lat));
  bcu_slot_model i_bcu_slot_model (.clk_i(clk), .rstn_i(rstn), .redir_i(rd),
    .squash_i(sq), .dly_i(dly), .done_o(done));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // next edge, then let its updates land
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // issue one word (prefix first if asked) and check the whole answer
  task automatic run(input logic [31:0] x, input logic hv, input logic [15:0] h);
    logic u, d, tk, bad;
    logic [31:0] t;
    int n;
    u = (x[31:26] == OPC_REG_UNCOND);
    d = u ? x[20] : x[25];
    bad = u & x[18] & !x[20];
    tk = u | ((x[24:21] == COND_LT) ? a[31] : (a != 32'h0));
    t = (x[31:26] == OPC_IMM_COND) ? {hv ? h : {16{x[15]}}, x[15:0]} : b;
    t = !tk ? pc + PC_STEP : (u & x[19]) ? t : pc + t;
    vld = 1'b1;
    if (hv) begin
      w = {OPC_PREFIX, 10'h0, h};
      step();
    end
    w = x;
    step();
    // keep offering a taken word while busy: it must be ignored
    vld = busy;
    w = 32'h9C20_0000;
    a = 32'h1;
    chk(ill, bad);
    if (!bad) begin
      chk(rd, tk);
      chk(npc, t);
      chk(sq, tk & !d);
      chk(lat, !tk ? 32'h1 : d ? 32'h2 : 32'h3);
      chk(lwe, u & x[18]);
      if (u & x[18]) begin
        chk(ldat, pc);
        chk(ldst, x[25:21]);
      end
    end
    chk({it, bt}, 2'h0);
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      n++;
      step();
      vld = busy;
      chk({rd, it, bt}, 3'h0);
    end
    vld = 1'b0;
    if (!bad) chk(!tk ? n == 0 : !d ? n == 2 : (n > dly && n < dly + 3), 1'b1);
    if (irq) begin
      n = 0;
      while (it !== 1'b1 && n < 4) begin
        n++;
        step();
      end
      chk({it, bt}, 2'h2);
      irq = 1'b0;
      n = 0;
      while (bt !== 1'b1 && n < 4) begin
        n++;
        step();
      end
      chk(bt, brk);
      brk = 1'b0;
      step();
    end
  endtask
  // reset, corner words, then a random mix
  initial begin
    rstn = 1'b0;
    vld = 1'b0;
    irq = 1'b0;
    brk = 1'b0;
    w = 32'h0;
    pc = 32'h0;
    a = 32'h8000_0000;
    b = 32'h0;
    dly = 3'h0;
    repeat (8) @(posedge clk);
    #1;
    chk({busy, rd, sq, lwe, ill}, 5'h0);
    rstn = 1'b1;
    run({OPC_IMM_COND, 1'b1, COND_LT, 5'h1, 16'h8000}, 1'b0, 16'h0);
    run({OPC_IMM_COND, 1'b0, COND_NE, 5'h1, 16'h7FFF}, 1'b1, 16'hFFFF);
    run({OPC_REG_UNCOND, 5'h2, 3'h1, 2'h0, 5'h4, 11'h0}, 1'b0, 16'h0);
    repeat (400) begin
      r = $random(seed);
      a = r[2:0] == 3'h0 ? 32'h0 : r[2:0] == 3'h1 ? 32'hFFFF_FFFF : $random(seed);
      b = $random(seed);
      pc = $random(seed);
      dly = r[5:3];
      irq = r[6] & r[7];
      brk = irq & r[8];
      case (r[10:9])
        2'h0: w = {OPC_REG_COND, r[11], r[17] ? COND_LT : COND_NE, 5'h3, 5'h4, 11'h0};
        2'h3: w = {OPC_REG_UNCOND, r[16:12], r[11], r[17], r[11] & r[18], 2'h0, 5'h4, 11'h0};
        default: w = {OPC_IMM_COND, r[11], r[17] ? COND_LT : COND_NE, 5'h3, r[31:16]};
      endcase
      run(w, (w[31:26] == OPC_IMM_COND) & r[19], r[31:16] ^ 16'hA5A5);
    end
    final_report();
  end
endmodule
